// file: hw/sdct_cmd_timing.sv
// sdct_cmd_timing: sdram command sequencer with apb registers
// assumes an apb master on clk and sdram clocked by sdram_clk_a/b
//
// Chosen here: the APB register port and the placing of the registers.
`default_nettype none
module sdct_cmd_timing (
   input  wire logic                         clk,
   input  wire logic                         resetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [sdct_pkg::DATA_W-1:0]  pwdata,
   output logic                              pready,
   output logic [sdct_pkg::DATA_W-1:0]       prdata,
   output logic                              pslverr,
   output logic                              sdram_clk_a,
   output logic                              sdram_clk_b,
   output logic                              sdram_select_n,
   output logic                              row_strobe_n,
   output logic                              col_strobe_n,
   output logic                              write_enable_n,
   output logic [sdct_pkg::ROW_W-1:0]        mem_addr_bus,
   input  wire logic [sdct_pkg::DATA_W-1:0]  mem_data_bus_i,
   output logic [sdct_pkg::DATA_W-1:0]       mem_data_bus_o,
   output logic                              mem_data_bus_oe_n
);
   import sdct_pkg::*;

   logic [1:0]        timingCat_r;
   logic              clkADiv2_r;
   logic              clkBDiv2_r;
   sdct_req_s         req_r;
   logic              reqPend_r;
   logic [DATA_W-1:0] rdBuf_r [BURST_LEN];
   logic [DATA_W-1:0] sramMem_r [BURST_LEN];
   logic [7:0]        hcnt_r;
   logic [1:0]        ph_r;
   logic [1:0]        phNxt;
   logic              clkANxt;
   logic              halfEn;
   logic              tick;
   sdct_state_e       state_r;
   sdct_cmd_s         cmd_r;
   logic [3:0]        wait_r;
   logic [3:0]        sinceAct_r;
   logic [3:0]        sincePre_r;
   logic [3:0]        sinceCol_r;
   logic [3:0]        sinceWr_r;
   logic [1:0]        beat_r;
   logic [3:0]        sramCnt_r;
   logic [3:0]        tRcd;
   logic [3:0]        tRp;
   logic [3:0]        tCl;
   logic [3:0]        tRas;
   logic [3:0]        tRc;
   logic              busy;
   logic              dataOk;
   logic              actGo;
   logic              sramGo;
   logic              colGo;
   logic              preGo;
   logic              capEn;
   logic              lastWr;
   logic              access;
   logic              stall;
   logic              fInValid;
   logic              fInReady;
   logic              fOutValid;
   logic              fOutReady;
   logic [DATA_W-1:0] fOutData;

   assign sdram_select_n = cmd_r.cs_n;
   assign row_strobe_n   = cmd_r.ras_n;
   assign col_strobe_n   = cmd_r.cas_n;
   assign write_enable_n = cmd_r.we_n;

   sdct_fifo #(
      .W (DATA_W),
      .D (FIFO_DEPTH)
   ) wrFifo (
      .clk      (clk),
      .resetn   (resetn),
      .inValid  (fInValid),
      .inReady  (fInReady),
      .inData   (pwdata),
      .outValid (fOutValid),
      .outReady (fOutReady),
      .outData  (fOutData)
   );

   // sdram clock generation and the command tick at clock a rise
   always_comb
   begin
      halfEn  = (hcnt_r == HALF_LAST);
      phNxt   = ph_r + 2'h1;
      clkANxt = clkADiv2_r ? phNxt[1] : phNxt[0];
      tick    = halfEn && clkANxt && !sdram_clk_a;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         hcnt_r      <= 8'h00;
         ph_r        <= 2'h0;
         sdram_clk_a <= 1'b0;
         sdram_clk_b <= 1'b0;
      end
      else
      begin
         hcnt_r <= halfEn ? 8'h00 : hcnt_r + 8'h01;
         if (halfEn)
         begin
            ph_r        <= phNxt;
            sdram_clk_a <= clkANxt;
            sdram_clk_b <= clkBDiv2_r ? phNxt[1] : phNxt[0];
         end
      end
   end

   // timing figures of the selected category
   always_comb
   begin
      tRcd   = TRCD[timingCat_r];
      tRp    = TRP[timingCat_r];
      tCl    = TCL[timingCat_r];
      tRas   = TRAS[timingCat_r];
      tRc    = TRC[timingCat_r];
      busy   = reqPend_r || (state_r != ST_IDLE);
      dataOk = !req_r.wr || !fInReady;
      sramGo = (state_r == ST_IDLE) && reqPend_r && req_r.sram && dataOk;
      actGo  = (state_r == ST_IDLE) && tick && reqPend_r && !req_r.sram && dataOk
               && (sinceAct_r >= tRc) && (sincePre_r >= tRp);
      colGo  = (state_r == ST_RCD) && tick && (wait_r == 4'h0);
      preGo  = tick && (((state_r == ST_WREC) && (wait_r == 4'h0))
               || ((state_r == ST_PREW) && (sinceAct_r >= tRas)));
      capEn  = tick && (((state_r == ST_RLAT) && (wait_r == 4'h0)) || (state_r == ST_RBST));
      lastWr = tick && (state_r == ST_WBST) && (beat_r == BEAT_LAST - 2'h1);
      fOutReady = (tick && ((colGo && req_r.wr) || (state_r == ST_WBST)))
                  || ((state_r == ST_SRAM) && req_r.wr && (sramCnt_r < 4'(BURST_LEN)));
   end

   // apb slave: one wait state, write data stalls while the fifo is full
   always_comb
   begin
      access   = psel && penable && !pready;
      stall    = pwrite && (paddr == REG_WDAT) && !fInReady;
      fInValid = access && pwrite && (paddr == REG_WDAT);
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= access && !stall;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (access && !stall)
         begin
            case (paddr)
               REG_CFG:  prdata <= {30'h0, timingCat_r};
               REG_REF:  prdata <= {30'h0, clkBDiv2_r, clkADiv2_r};
               REG_CMD:  pslverr <= pwrite && busy;
               REG_WDAT: prdata <= '0;
               REG_STAT: prdata <= {29'h0, fOutValid, !fInReady, busy};
               REG_RD0:  prdata <= rdBuf_r[0];
               REG_RD1:  prdata <= rdBuf_r[1];
               REG_RD2:  prdata <= rdBuf_r[2];
               REG_RD3:  prdata <= rdBuf_r[3];
               default:  pslverr <= 1'b1;
            endcase
         end
      end
   end

   // software control: category, clock dividers, request
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         timingCat_r <= CFG_RST;
         clkADiv2_r  <= REF_RST[0];
         clkBDiv2_r  <= REF_RST[1];
         req_r       <= '0;
         reqPend_r   <= 1'b0;
      end
      else
      begin
         if (access && pwrite && (paddr == REG_CFG))
         begin
            timingCat_r <= pwdata[1:0];
         end
         if (access && pwrite && (paddr == REG_REF))
         begin
            clkADiv2_r <= pwdata[0];
            clkBDiv2_r <= pwdata[1];
         end
         if (access && pwrite && (paddr == REG_CMD) && !busy)
         begin
            req_r.wr   <= pwdata[CMD_WR_BIT];
            req_r.sram <= pwdata[CMD_SRAM_BIT];
            req_r.row  <= pwdata[CMD_ROW_LSB +: ROW_W];
            req_r.col  <= pwdata[CMD_COL_LSB +: COL_W];
            reqPend_r  <= 1'b1;
         end
         else if (actGo || sramGo)
         begin
            reqPend_r <= 1'b0;
         end
      end
   end

   // elapsed sdram clocks since activate, precharge, column command and last write beat
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sinceAct_r <= SAT;
         sincePre_r <= SAT;
         sinceCol_r <= SAT;
         sinceWr_r  <= SAT;
      end
      else if (tick)
      begin
         sinceAct_r <= actGo ? 4'h1 : (sinceAct_r == SAT) ? SAT : sinceAct_r + 4'h1;
         sincePre_r <= preGo ? 4'h1 : (sincePre_r == SAT) ? SAT : sincePre_r + 4'h1;
         sinceCol_r <= colGo ? 4'h1 : (sinceCol_r == SAT) ? SAT : sinceCol_r + 4'h1;
         sinceWr_r  <= lastWr ? 4'h1 : (sinceWr_r == SAT) ? SAT : sinceWr_r + 4'h1;
      end
   end

   // command sequencer; pins change only at the clock a rise
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r           <= ST_IDLE;
         cmd_r             <= CMD_NOP;
         wait_r            <= 4'h0;
         beat_r            <= 2'h0;
         sramCnt_r         <= 4'h0;
         mem_addr_bus      <= '0;
         mem_data_bus_o    <= '0;
         mem_data_bus_oe_n <= 1'b1;
      end
      else
      begin
         if (tick)
         begin
            cmd_r <= CMD_NOP;
         end
         if (capEn)
         begin
            rdBuf_r[beat_r] <= mem_data_bus_i;
         end
         case (state_r)
            ST_IDLE:
            begin
               if (sramGo)
               begin
                  sramCnt_r <= 4'h0;
                  state_r   <= ST_SRAM;
               end
               else if (actGo)
               begin
                  cmd_r        <= CMD_ACT;
                  mem_addr_bus <= req_r.row;
                  wait_r       <= tRcd - 4'h1;
                  state_r      <= ST_RCD;
               end
            end
            ST_RCD:
            begin
               if (colGo)
               begin
                  cmd_r        <= req_r.wr ? CMD_WR : CMD_RD;
                  mem_addr_bus <= {{(ROW_W - COL_W){1'b0}}, req_r.col};
                  beat_r       <= 2'h0;
                  if (req_r.wr)
                  begin
                     mem_data_bus_o    <= fOutData;
                     mem_data_bus_oe_n <= 1'b0;
                     state_r           <= ST_WBST;
                  end
                  else
                  begin
                     wait_r  <= tCl - 4'h1;
                     state_r <= ST_RLAT;
                  end
               end
               else if (tick)
               begin
                  wait_r <= wait_r - 4'h1;
               end
            end
            ST_WBST:
            begin
               if (tick)
               begin
                  beat_r         <= beat_r + 2'h1;
                  mem_data_bus_o <= fOutData;
                  if (lastWr)
                  begin
                     wait_r  <= TWR - 4'h1;
                     state_r <= ST_WREC;
                  end
               end
            end
            ST_WREC:
            begin
               if (tick)
               begin
                  mem_data_bus_oe_n <= 1'b1;
                  wait_r            <= wait_r - 4'h1;
               end
            end
            ST_RLAT:
            begin
               if (capEn)
               begin
                  beat_r  <= 2'h1;
                  state_r <= ST_RBST;
               end
               else if (tick)
               begin
                  wait_r <= wait_r - 4'h1;
               end
            end
            ST_RBST:
            begin
               if (tick)
               begin
                  beat_r <= beat_r + 2'h1;
                  if (beat_r == BEAT_LAST)
                  begin
                     state_r <= ST_PREW;
                  end
               end
            end
            ST_PREW:
            begin
            end
            ST_RP:
            begin
               if (tick)
               begin
                  wait_r <= wait_r - 4'h1;
                  if (wait_r == 4'h0)
                  begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_SRAM:
            begin
               sramCnt_r <= sramCnt_r + 4'h1;
               if (fOutReady)
               begin
                  sramMem_r[sramCnt_r[1:0]] <= fOutData;
               end
               if (sramCnt_r == (req_r.wr ? SRAM_WR_CLKS : SRAM_RD_CLKS) - 4'h1)
               begin
                  state_r <= ST_IDLE;
                  if (!req_r.wr)
                  begin
                     rdBuf_r <= sramMem_r;
                  end
               end
            end
            default:
            begin
               state_r <= ST_IDLE;
            end
         endcase
         if (preGo)
         begin
            cmd_r        <= CMD_PRE;
            mem_addr_bus <= ROW_W'(1 << PRE_ALL_BIT);
            wait_r       <= tRp - 4'h2;
            state_r      <= ST_RP;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence sramWrRun;
      (state_r == ST_SRAM) [*7];
   endsequence

   sequence sramRdRun;
      (state_r == ST_SRAM) [*8] ##1 (state_r == ST_SRAM);
   endsequence

   property sramBurst;
      sramGo |=> if (req_r.wr) (sramWrRun ##1 (state_r == ST_IDLE)) else (sramRdRun ##1 (state_r == ST_IDLE));
   endproperty

   strobe_hold_a: assert property (!tick |=> $stable(cmd_r))
      else $error("command pins moved between sdram clock rises");
   strobe_once_a: assert property ((tick && !actGo && !colGo && !preGo) |=> cmd_r == CMD_NOP)
      else $error("command strobe held past one sdram clock");
   cas_gap_a: assert property (colGo |-> sinceCol_r >= CAS_GAP)
      else $error("column strobes too close");
   act_to_col_a: assert property (colGo |-> sinceAct_r == tRcd)
      else $error("activate to column delay wrong");
   pre_interval_a: assert property (actGo |-> sincePre_r >= tRp)
      else $error("precharge interval too short");
   cas_latency_a: assert property ((capEn && state_r == ST_RLAT) |-> sinceCol_r == tCl)
      else $error("read data captured at wrong latency");
   row_active_a: assert property (preGo |-> sinceAct_r >= tRas)
      else $error("row closed too early");
   row_cycle_a: assert property (actGo |-> sinceAct_r >= tRc)
      else $error("activates too close");
   write_recovery_a: assert property ((preGo && state_r == ST_WREC) |-> sinceWr_r == TWR)
      else $error("write recovery not two clocks");
   clk_divide_a: assert property ((halfEn && !clkADiv2_r) |=> sdram_clk_a != $past(sdram_clk_a))
      else $error("undivided sdram clock did not toggle");
   sram_burst_a: assert property (sramBurst)
      else $error("internal sram burst length wrong");
endmodule
`default_nettype wire

// file: hw/sdct_pkg.sv
// sdct_pkg: constants and types of the sdram command timing block
// assumes a 250 MHz system clock and an apb register bus
`default_nettype none
package sdct_pkg;
   localparam int CLK_MHZ        = 250;
   localparam int MEMCLK_MAX_MHZ = 104;
   localparam int MEMCLK_MIN_MHZ = 26;
   // clk cycles per memory clock half period, rounded up to stay at or below max
   localparam int HALF_CLKS = (CLK_MHZ + 2 * MEMCLK_MAX_MHZ - 1) / (2 * MEMCLK_MAX_MHZ);
   localparam logic [7:0] HALF_LAST = 8'(HALF_CLKS - 1);
   localparam int SDCLK_MIN_MHZ = MEMCLK_MIN_MHZ / 2;

   localparam int DATA_W     = 32;
   localparam int ROW_W      = 13;
   localparam int COL_W      = 9;
   localparam int FIFO_DEPTH = 4;
   localparam int BURST_LEN  = 4;
   localparam logic [1:0] BEAT_LAST = 2'h3;
   localparam int PRE_ALL_BIT = 10;

   localparam logic [7:0] REG_CFG  = 8'h00;
   localparam logic [7:0] REG_REF  = 8'h04;
   localparam logic [7:0] REG_CMD  = 8'h08;
   localparam logic [7:0] REG_WDAT = 8'h0C;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam logic [7:0] REG_RD0  = 8'h14;
   localparam logic [7:0] REG_RD1  = 8'h18;
   localparam logic [7:0] REG_RD2  = 8'h1C;
   localparam logic [7:0] REG_RD3  = 8'h20;

   localparam logic [1:0] CFG_RST = 2'h3;
   localparam logic [1:0] REF_RST = 2'h0;
   localparam int CMD_WR_BIT   = 0;
   localparam int CMD_SRAM_BIT = 1;
   localparam int CMD_ROW_LSB  = 2;
   localparam int CMD_COL_LSB  = 15;

   localparam logic [3:0] TWR          = 4'h2;
   localparam logic [3:0] CAS_GAP      = 4'h2;
   localparam logic [3:0] SRAM_RD_CLKS = 4'h9;
   localparam logic [3:0] SRAM_WR_CLKS = 4'h7;
   localparam logic [3:0] SAT          = 4'hF;

   // per timing category: rcd, rp, cas latency, ras, rc
   localparam logic [3:0] TRCD [4] = '{4'h1, 4'h2, 4'h3, 4'h3};
   localparam logic [3:0] TRP  [4] = '{4'h2, 4'h2, 4'h3, 4'h3};
   localparam logic [3:0] TCL  [4] = '{4'h2, 4'h2, 4'h3, 4'h3};
   localparam logic [3:0] TRAS [4] = '{4'h3, 4'h5, 4'h6, 4'h7};
   localparam logic [3:0] TRC  [4] = '{4'h4, 4'h7, 4'h9, 4'hB};

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } sdct_cmd_s;

   localparam sdct_cmd_s CMD_NOP = 4'hF;
   localparam sdct_cmd_s CMD_ACT = 4'h3;
   localparam sdct_cmd_s CMD_RD  = 4'h5;
   localparam sdct_cmd_s CMD_WR  = 4'h4;
   localparam sdct_cmd_s CMD_PRE = 4'h2;

   typedef struct packed {
      logic [ROW_W-1:0] row;
      logic [COL_W-1:0] col;
      logic             sram;
      logic             wr;
   } sdct_req_s;

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_RCD  = 9'h002,
      ST_WBST = 9'h004,
      ST_WREC = 9'h008,
      ST_RLAT = 9'h010,
      ST_RBST = 9'h020,
      ST_PREW = 9'h040,
      ST_RP   = 9'h080,
      ST_SRAM = 9'h100
   } sdct_state_e;
endpackage
`default_nettype wire

// file: hw/sdct_fifo.sv
// sdct_fifo: small valid/ready fifo for write data
// assumes one clock, asynchronous active-low reset
`default_nettype none
module sdct_fifo #(
   parameter int W = 32,
   parameter int D = 4
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL = (AW + 1)'(D);
   localparam logic [AW-1:0] PLAST = AW'(D - 1);

   logic [W-1:0]  mem_r [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   logic          push;
   logic          pop;

   assign inReady  = (cnt_r != FULL);
   assign outValid = (cnt_r != '0);
   assign outData  = mem_r[rp_r];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_r[wp_r] <= inData;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wp_r <= (wp_r == PLAST) ? '0 : wp_r + 1'b1;
         end
         if (pop)
         begin
            rp_r <= (rp_r == PLAST) ? '0 : rp_r + 1'b1;
         end
         if (push && !pop)
         begin
            cnt_r <= cnt_r + 1'b1;
         end
         else if (pop && !push)
         begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: verification/sdct_sdram_model.sv
// sdct_sdram_model: behavioural sdram keeping one four-beat burst
// assumes commands launched at sdram_clk_a rise, cas latency set by the bench
`default_nettype none
module sdct_sdram_model (
   input  wire logic                        sdram_clk_a,
   input  wire logic                        sdram_select_n,
   input  wire logic                        row_strobe_n,
   input  wire logic                        col_strobe_n,
   input  wire logic                        write_enable_n,
   input  wire logic [sdct_pkg::DATA_W-1:0] mem_data_bus_o,
   input  wire logic [3:0]                  casLat,
   output logic [sdct_pkg::DATA_W-1:0]      mem_data_bus_i
);
   timeunit 1ns;
   timeprecision 1ps;
   import sdct_pkg::*;
   sdct_cmd_s         cmdL = CMD_NOP;
   logic [DATA_W-1:0] datL;
   logic [DATA_W-1:0] store [4];
   int                wp = 4;
   int                k = -1;

   initial mem_data_bus_i = '0;
   // latch mid-period, acted on at the next rise
   always @(negedge sdram_clk_a)
   begin
      cmdL = '{sdram_select_n, row_strobe_n, col_strobe_n, write_enable_n};
      datL = mem_data_bus_o;
   end

   always @(posedge sdram_clk_a)
   begin
      if (cmdL === CMD_WR)
         wp = 0;
      if (wp < 4)
      begin
         store[wp] = datL;
         wp = wp + 1;
      end
      if (cmdL === CMD_RD)
         k = 0;
      else if (k >= 0 && k < 8)
         k = k + 1;
      // released bus toggles so a stale beat never matches
      if (k >= int'(casLat) - 2 && k <= int'(casLat) + 1)
         mem_data_bus_i <= store[k - int'(casLat) + 2];
      else
         mem_data_bus_i <= ~mem_data_bus_i;
   end
endmodule
`default_nettype wire

// file: verification/sdram_command_timing_tb.sv
// sdram_command_timing_tb: apb-driven bursts per timing category, pin timing watch
// assumes sdct_cmd_timing and the behavioural sdram model
`default_nettype none
module sdram_command_timing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sdct_pkg::*;
   logic              clk = 1'b0;
   logic              resetn = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata, rdat, dqo, dqi;
   logic              pready, pslverr, err, sdram_clk_a, sdram_clk_b, oeN, prevA, prevB, lastWr, sram;
   logic              sdram_select_n, row_strobe_n, col_strobe_n, write_enable_n;
   logic [ROW_W-1:0]  mem_addr_bus, rowV;
   logic [COL_W-1:0]  colV;
   logic [3:0]        lat = 4'h3;
   sdct_cmd_s         cmd, prevCmd;
   int failures, total_checks, tn, cmds, aLen, bLen, aPer, bPer;
   int lastAct = -99, lastPre = -99, lastCas = -99;
   int expRow [6];
   // cat, rcd, rp, cl, ras, rc; last row targets internal sram
   int rows [5][6] = '{'{0, 1, 2, 2, 3, 4}, '{1, 2, 2, 2, 5, 7}, '{2, 3, 3, 3, 6, 9},
                       '{3, 3, 3, 3, 7, 11}, '{3, 3, 3, 3, 7, 11}};

   always #2 clk = ~clk;
   assign cmd = '{sdram_select_n, row_strobe_n, col_strobe_n, write_enable_n};

   sdct_cmd_timing dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .sdram_clk_a(sdram_clk_a), .sdram_clk_b(sdram_clk_b), .sdram_select_n(sdram_select_n),
      .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_enable_n(write_enable_n),
      .mem_addr_bus(mem_addr_bus), .mem_data_bus_i(dqi), .mem_data_bus_o(dqo), .mem_data_bus_oe_n(oeN));
   sdct_sdram_model mem (.sdram_clk_a(sdram_clk_a), .sdram_select_n(sdram_select_n),
      .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_enable_n(write_enable_n),
      .mem_data_bus_o(dqo), .casLat(lat), .mem_data_bus_i(dqi));

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      total_checks++;
      if (got !== want)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, want);
      end
   endtask

   task automatic results;
      if (failures == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic waitIdle;
      do
         apb(1'b0, REG_STAT, '0);
      while (rdat[0] !== 1'b0);
   endtask

   task automatic burst(input int i);
      int c0;
      expRow = rows[i];
      lat = 4'(expRow[3]);
      rowV = 13'(i * 300 + 5);
      colV = 9'(i * 40 + 3);
      sram = (i == 4);
      apb(1'b1, REG_CFG, 32'(expRow[0]));
      for (int j = 0; j < 4; j++)
         apb(1'b1, REG_WDAT, 32'hC0DE0000 + 32'(i * 16 + j));
      c0 = cmds;
      apb(1'b1, REG_CMD, {8'h00, colV, rowV, sram, 1'b1});
      waitIdle();
      apb(1'b1, REG_CMD, {8'h00, colV, rowV, sram, 1'b0});
      waitIdle();
      for (int j = 0; j < 4; j++)
      begin
         apb(1'b0, REG_RD0 + 8'(4 * j), '0);
         chk(rdat, 32'hC0DE0000 + 32'(i * 16 + j));
      end
      if (sram)
         chk(32'(cmds), 32'(c0));
   endtask

   always @(posedge clk)
   begin
      prevA <= sdram_clk_a;
      prevB <= sdram_clk_b;
      aLen <= (sdram_clk_a && !prevA) ? 1 : aLen + 1;
      bLen <= (sdram_clk_b && !prevB) ? 1 : bLen + 1;
      if (sdram_clk_a && !prevA)
         aPer <= aLen;
      if (sdram_clk_b && !prevB)
         bPer <= bLen;
      if (sdram_clk_a === 1'b1 && prevA === 1'b0 && resetn)
      begin
         tn++;
         if (cmd !== CMD_NOP)
         begin
            cmds++;
            chk(32'(cmd !== prevCmd), 1);
         end
         if (cmd === CMD_ACT)
         begin
            chk(32'(tn - lastAct >= expRow[5]), 1);
            chk(32'(tn - lastPre >= expRow[2]), 1);
            chk(32'(mem_addr_bus), 32'(rowV));
            lastAct = tn;
         end
         if (cmd === CMD_RD || cmd === CMD_WR)
         begin
            chk(32'(tn - lastAct), 32'(expRow[1]));
            chk(32'(tn - lastCas >= 2), 1);
            chk(32'(mem_addr_bus[COL_W-1:0]), 32'(colV));
            chk(32'(oeN), 32'(cmd === CMD_RD));
            lastCas = tn;
            lastWr = (cmd === CMD_WR);
         end
         if (cmd === CMD_PRE)
         begin
            chk(32'(mem_addr_bus[PRE_ALL_BIT]), 1);
            chk(32'(oeN), 1);
            chk(32'(tn - lastAct >= expRow[4]), 1);
            if (lastWr)
               chk(32'(tn - lastCas), 5);
            lastPre = tn;
         end
         prevCmd = cmd;
      end
   end

   initial
   begin
      repeat (60000) @(posedge clk);
      failures++;
      results();
   end

   initial
   begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 5; i++)
         burst(i);
      // divider settings, both clocks
      for (int r = 0; r < 4; r++)
      begin
         apb(1'b1, REG_REF, 32'(r));
         repeat (24) @(posedge clk);
         chk(32'(aPer), 32'(2 * HALF_CLKS * ((r & 1) + 1)));
         chk(32'(bPer), 32'(2 * HALF_CLKS * ((r >> 1) + 1)));
      end
      apb(1'b1, REG_REF, '0);
      // command while a partial fifo holds the sequencer busy
      for (int j = 0; j < 3; j++)
         apb(1'b1, REG_WDAT, 32'h5A5A0000 + 32'(j));
      apb(1'b1, REG_CMD, {8'h00, colV, rowV, 2'b01});
      apb(1'b0, REG_STAT, '0);
      chk(32'(rdat[2:0]), 32'h5);
      apb(1'b1, REG_CMD, {8'h00, colV, rowV, 2'b01});
      chk(32'(err), 1);
      apb(1'b1, REG_WDAT, 32'h5A5A0003);
      waitIdle();
      apb(1'b0, 8'hFC, '0);
      chk({rdat[30:0], err}, 32'h1);
      // mid-run reset returns registers and pins to rest
      apb(1'b1, REG_CFG, 32'h1);
      apb(1'b1, REG_REF, 32'h3);
      resetn <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      chk(32'({sdram_clk_a, cmd, oeN, pready}), 32'h3E);
      resetn <= 1'b1;
      @(posedge clk);
      apb(1'b0, REG_CFG, '0);
      chk(rdat, 32'(CFG_RST));
      apb(1'b0, REG_REF, '0);
      chk(rdat, 32'(REF_RST));
      results();
   end
endmodule
`default_nettype wire
